// ### hdl/pcm_path_monitor.sv
`include "pcm_defines.svh"
// Operation
// - Check bits of each submultiframe are compared with the crc-4 of the previous one.
// - The A bit gives the remote defect, one meaning far receiver defect, zero normal.
// - Each E bit at zero is one far-end errored block and is counted.
// - Degraded and remote defect states are derived by persistence filters.
// - Interworking status sets after five seconds of far count above 990 without far ds.
// - Interworking status clears after five seconds of far count below 990 or far ds.
// - Interworking status only means something in automatic interworking mode.
// - Remote defect cause is defect and monitoring and its report enable.
// - A select input picks align word errors or crc violations as block errors.
// - With crc select low any errored align word bit errors the near block.
// - With crc select high multiframe loss makes a near-end defect second.
// - Far-end blocks accumulate only while crc counting is selected.
// - The count source choice is independent of the interworking mode input.
module pcm_path_monitor import pcm_pkg::*; #(
  parameter int RDI_FRAMES = `PCM_RDI_FRAMES,
  parameter int DEG_W = 4
) (
  input wire logic clock, // 125 mhz system clock
  input wire logic rst_b, // async reset, active low
  input wire logic line_clk, // line bit clock, async
  input wire logic line_data, // line data
  input wire logic line_frame_start, // high with first bit of a frame
  input wire logic server_fail_in, // upstream server fail, async
  input wire logic multiframe_loss_in, // upstream multiframe loss, async
  input wire logic equipment_defect, // local equipment defect
  input wire logic one_second_tick, // one-cycle pulse per second
  input wire logic monitoring_active, // monitoring enabled
  input wire logic remote_defect_report_en, // report remote defect cause
  input wire logic server_fail_report_en, // report server fail cause
  input wire logic crc_count_select, // 1 crc-4, 0 align word errors
  input wire logic auto_interwork_mode, // upstream in automatic interworking
  input wire logic [DEG_W-1:0] deg_seconds, // bad seconds to declare degrade
  input wire logic [`PCM_CNT_W-1:0] deg_threshold, // errored blocks for a bad second
  output logic trail_fail_out, // trail signal fail
  output logic trail_degrade_out, // trail signal degrade
  output logic degrade_fault_cause, // degrade cause
  output logic remote_defect_fault_cause, // remote defect cause
  output logic server_fail_fault_cause, // server fail cause
  output logic remote_defect, // filtered remote defect
  output logic degraded_defect, // filtered degrade
  output logic crc_interwork_status, // interworking status
  output logic near_block_error, // pulse, near-end errored block
  output logic far_block_error, // pulse, far-end errored block
  output logic align_word_error, // pulse, errored align word
  output logic perf_valid, // pulse, perf_second updated
  output pcm_second_s perf_second // last second's results
);
  if (RDI_FRAMES < 1 || RDI_FRAMES > 255) begin : g_bad_rdi
    $error("RDI_FRAMES out of range");
  end
  if (DEG_W < 1 || DEG_W > 16) begin : g_bad_deg
    $error("DEG_W out of range");
  end

  logic [2:0] ck_sync;
  logic [1:0] d_sync;
  logic [1:0] fs_sync;
  logic [1:0] sf_sync;
  logic [1:0] lom_sync;

  // two stages on line data, frame start, server fail and multiframe loss, three on the line clock; edges seen on the second and third
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ck_sync <= 3'h0;
      d_sync <= 2'h0;
      fs_sync <= 2'h0;
      sf_sync <= 2'h0;
      lom_sync <= 2'h0;
    end else begin
      ck_sync <= {ck_sync[1:0], line_clk};
      d_sync <= {d_sync[0], line_data};
      fs_sync <= {fs_sync[0], line_frame_start};
      sf_sync <= {sf_sync[0], server_fail_in};
      lom_sync <= {lom_sync[0], multiframe_loss_in};
    end
  end

  wire bit_en = ck_sync[1] && !ck_sync[2];
  wire line_bit = d_sync[1];
  wire server_fail = sf_sync[1];
  wire mf_loss = lom_sync[1];

  logic [7:0] bit_pos;
  logic [3:0] frm;
  logic si_bit;
  logic [4:0] mfas_sh;
  logic [3:0] rx_c;
  logic fas_acc;
  pcm_mf_e mf_state;
  pcm_mf_e next_mf_state;

  // position within frame and frame type
  wire [7:0] cur_pos = fs_sync[1] ? 8'h00 : bit_pos;
  wire pos_si = cur_pos == 8'h00;
  wire pos_nfas_ind = cur_pos == 8'h01;
  wire nfas = frm[0];
  wire mf_lock = mf_state == PCM_LOCK;
  wire mfas_hit = bit_en && pos_nfas_ind && line_bit && ({mfas_sh, si_bit} == `PCM_MFAS_WORD);

  // pattern bit for align word positions 1..7, msb first
  wire [6:0] fas_word = `PCM_FAS_WORD;
  wire [2:0] fas_idx = 3'(`PCM_POS_FAS_LAST - cur_pos);
  wire fas_pos = !nfas && cur_pos >= 8'h01 && cur_pos <= `PCM_POS_FAS_LAST;
  wire fas_bit_bad = fas_pos && (line_bit != fas_word[fas_idx]);
  wire fas_evt = bit_en && !nfas && cur_pos == `PCM_POS_FAS_LAST && (fas_acc || fas_bit_bad);

  // frame counter; parity follows the received frame type only while not locked (hunt or lost)
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bit_pos <= 8'h00;
      frm <= 4'h0;
      si_bit <= 1'b0;
      mfas_sh <= 5'h00;
    end else if (bit_en) begin
      bit_pos <= 8'(cur_pos + 1'b1);
      if (pos_si) si_bit <= line_bit;
      if (pos_nfas_ind && line_bit) mfas_sh <= {mfas_sh[3:0], si_bit};
      if (cur_pos == `PCM_POS_LAST) frm <= 4'(frm + 1'b1);
      else if (mfas_hit && !mf_lock) frm <= `PCM_MFAS_FRAME;
      else if (pos_nfas_ind && !mf_lock) frm <= line_bit ? (frm | 4'h1) : (frm & 4'he);
    end
  end

  // multiframe search; upstream loss forces a new hunt
  always_comb begin
    next_mf_state = mf_state;
    case (mf_state)
      PCM_HUNT: if (mfas_hit) next_mf_state = PCM_LOCK;
      PCM_LOCK: if (mf_loss) next_mf_state = PCM_LOST;
      PCM_LOST: if (!mf_loss) next_mf_state = PCM_HUNT;
      default: next_mf_state = PCM_HUNT;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) mf_state <= PCM_HUNT;
    else mf_state <= next_mf_state;
  end

  // check bits sit in bit 1 of each align frame, c1 first
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_c <= 4'h0;
      fas_acc <= 1'b0;
    end else if (bit_en) begin
      if (pos_si && !nfas) rx_c[~frm[2:1]] <= line_bit;
      // restart at the first pattern bit, but keep an error seen on that bit
      if (fas_pos) fas_acc <= ((cur_pos != 8'h01) && fas_acc) || fas_bit_bad;
    end
  end

  wire crc_check = bit_en && pos_nfas_ind && !nfas && frm[2:1] == 2'h3 && mf_lock;
  wire crc_bit = (pos_si && !nfas) ? 1'b0 : line_bit;
  wire smf_start = pos_si && frm[2:0] == 3'h0;
  wire crc_mismatch;

  pcm_crc4 u_crc (
    .clock(clock),
    .rst_b(rst_b),
    .clear(!mf_lock),
    .bit_en(bit_en),
    .bit_in(crc_bit),
    .smf_start(smf_start),
    .check(crc_check),
    .rx_crc(rx_c),
    .mismatch(crc_mismatch)
  );

  // e bits in frames 13 and 15, a zero flags a far errored block
  wire e_pos = pos_si && (frm == `PCM_E1_FRAME || frm == `PCM_E2_FRAME);
  wire far_evt = bit_en && e_pos && mf_lock && !line_bit;
  wire a_eval = bit_en && nfas && cur_pos == `PCM_POS_ABIT;

  pcm_persist #(.W(8)) u_rdi (
    .clock(clock),
    .rst_b(rst_b),
    .clear(server_fail),
    .eval(a_eval),
    .set_cond(line_bit),
    .clr_cond(!line_bit),
    .consec(8'(RDI_FRAMES)),
    .state(remote_defect)
  );

  // error source chosen here only, whatever the upstream mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      near_block_error <= 1'b0;
      far_block_error <= 1'b0;
      align_word_error <= 1'b0;
    end else begin
      near_block_error <= crc_count_select ? crc_mismatch : fas_evt;
      far_block_error <= far_evt && crc_count_select;
      align_word_error <= fas_evt;
    end
  end

  // consequent actions and correlations, all registered
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      trail_fail_out <= 1'b0;
      trail_degrade_out <= 1'b0;
      degrade_fault_cause <= 1'b0;
      remote_defect_fault_cause <= 1'b0;
      server_fail_fault_cause <= 1'b0;
    end else begin
      trail_fail_out <= server_fail;
      trail_degrade_out <= degraded_defect;
      degrade_fault_cause <= degraded_defect && monitoring_active;
      remote_defect_fault_cause <= remote_defect && monitoring_active
                                   && remote_defect_report_en;
      server_fail_fault_cause <= server_fail && monitoring_active
                                 && server_fail_report_en;
    end
  end

  // counts saturate rather than wrap, a wrapped second would look clean
  function automatic pcm_count_t sat_inc(input pcm_count_t a, input logic inc);
    return (inc && a != '1) ? `PCM_CNT_W'(a + 1'b1) : a;
  endfunction : sat_inc

  pcm_count_t near_acc;
  pcm_count_t far_acc;
  logic near_ds_acc;
  logic far_ds_acc;
  wire near_ds_evt = trail_fail_out || (mf_loss && crc_count_select)
                     || equipment_defect;

  // events in the tick cycle go into the closing second, none lost
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      near_acc <= '0;
      far_acc <= '0;
      near_ds_acc <= 1'b0;
      far_ds_acc <= 1'b0;
      perf_second <= '0;
      perf_valid <= 1'b0;
    end else begin
      perf_valid <= one_second_tick;
      if (one_second_tick) begin
        perf_second.near_count <= sat_inc(near_acc, near_block_error);
        perf_second.near_ds <= near_ds_acc || near_ds_evt;
        perf_second.far_count <= sat_inc(far_acc, far_block_error);
        perf_second.far_ds <= far_ds_acc || remote_defect;
        near_acc <= '0;
        far_acc <= '0;
        near_ds_acc <= 1'b0;
        far_ds_acc <= 1'b0;
      end else begin
        near_acc <= sat_inc(near_acc, near_block_error);
        far_acc <= sat_inc(far_acc, far_block_error);
        near_ds_acc <= near_ds_acc || near_ds_evt;
        far_ds_acc <= far_ds_acc || remote_defect;
      end
    end
  end

  // degrade: consecutive seconds at or above the threshold
  pcm_persist #(.W(DEG_W)) u_deg (
    .clock(clock),
    .rst_b(rst_b),
    .clear(1'b0),
    .eval(perf_valid),
    .set_cond(perf_second.near_count >= deg_threshold),
    .clr_cond(perf_second.near_count < deg_threshold),
    .consec(deg_seconds),
    .state(degraded_defect)
  );

  // exactly 990 without far ds counts toward neither, so both runs restart
  wire rnci_set = perf_second.far_count > `PCM_RNCI_LIMIT && !perf_second.far_ds;
  wire rnci_clr = perf_second.far_count < `PCM_RNCI_LIMIT || perf_second.far_ds;

  pcm_persist #(.W(3)) u_rnci (
    .clock(clock),
    .rst_b(rst_b),
    .clear(!auto_interwork_mode),
    .eval(perf_valid),
    .set_cond(rnci_set),
    .clr_cond(rnci_clr),
    .consec(`PCM_RNCI_SECS),
    .state(crc_interwork_status)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_ssf;
    server_fail && monitoring_active && server_fail_report_en
      |=> trail_fail_out && server_fail_fault_cause;
  endproperty
  a_ssf: assert property (p_ssf) else $error("server fail not reported");

  property p_remote_defect_fault_cause;
    remote_defect_fault_cause |-> $past(remote_defect && monitoring_active
                                        && remote_defect_report_en);
  endproperty
  a_remote_defect_fault_cause: assert property (p_remote_defect_fault_cause) else $error("remote defect cause ungated");

  property p_fas_near;
    !crc_count_select && fas_evt |=> near_block_error && align_word_error;
  endproperty
  a_fas_near: assert property (p_fas_near) else $error("align error not counted");

  property p_crc_near;
    crc_count_select && crc_mismatch |=> near_block_error;
  endproperty
  a_crc_near: assert property (p_crc_near) else $error("crc violation not counted");

  property p_far_gate;
    far_block_error |-> $past(crc_count_select) && $past(mf_lock);
  endproperty
  a_far_gate: assert property (p_far_gate) else $error("far block outside crc mode");

  property p_lom_ds;
    one_second_tick && mf_loss && crc_count_select |=> perf_valid && perf_second.near_ds;
  endproperty
  a_lom_ds: assert property (p_lom_ds) else $error("loss second not marked");

  property p_far_ds;
    one_second_tick && remote_defect |=> perf_second.far_ds;
  endproperty
  a_far_ds: assert property (p_far_ds) else $error("far defect second missing");

  property p_rnci_mode;
    !auto_interwork_mode |=> !crc_interwork_status;
  endproperty
  a_rnci_mode: assert property (p_rnci_mode) else $error("status outside mode");
endmodule : pcm_path_monitor

// ### hdl/pcm_defines.svh
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH
// line framing
`define PCM_POS_LAST 8'hff
`define PCM_POS_ABIT 8'h02
`define PCM_POS_FAS_LAST 8'h07
`define PCM_FAS_WORD 7'h1b
`define PCM_MFAS_WORD 6'h0b
`define PCM_MFAS_FRAME 4'hb
`define PCM_E1_FRAME 4'hd
`define PCM_E2_FRAME 4'hf
// crc-4, x^4 + x + 1
`define PCM_CRC_POLY 4'h3
`define PCM_CRC_RESET 4'h0
// per-second counting
`define PCM_CNT_W 13
`define PCM_RNCI_LIMIT 13'h3de
`define PCM_RNCI_SECS 3'h5
`define PCM_RDI_FRAMES 5
`endif

// ### hdl/pcm_pkg.sv
`include "pcm_defines.svh"
package pcm_pkg;
  typedef logic [`PCM_CNT_W-1:0] pcm_count_t;
  // one second worth of performance data
  typedef struct packed {
    pcm_count_t near_count;
    logic near_ds;
    pcm_count_t far_count;
    logic far_ds;
  } pcm_second_s;
  // multiframe search, gray along hunt -> lock -> lost
  typedef enum logic [1:0] {
    PCM_HUNT = 2'h0,
    PCM_LOCK = 2'h1,
    PCM_LOST = 2'h3
  } pcm_mf_e;
endpackage : pcm_pkg

// ### hdl/pcm_crc4.sv
`include "pcm_defines.svh"
module pcm_crc4 import pcm_pkg::*; (
  input wire logic clock, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic clear, // drop history
  input wire logic bit_en, // one line bit this cycle
  input wire logic bit_in, // line bit, check bits zeroed
  input wire logic smf_start, // bit_en is first bit of a submultiframe
  input wire logic check, // rx_crc complete
  input wire logic [3:0] rx_crc, // received check bits, first bit msb
  output logic mismatch // one-cycle pulse
);
  logic [3:0] crc;
  logic [3:0] held;
  logic held_ok;
  logic primed;

  // serial division of message times x^4
  function automatic logic [3:0] crc_step(input logic [3:0] r, input logic b);
    return {r[2:0], 1'b0} ^ ((b ^ r[3]) ? `PCM_CRC_POLY : 4'h0);
  endfunction : crc_step

  wire [3:0] next_crc = crc_step(smf_start ? `PCM_CRC_RESET : crc, bit_in);

  // remainder of a finished block is held for the next block's check bits;
  // a block cut short by the lock is never judged, primed marks a whole one
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      crc <= `PCM_CRC_RESET;
      held <= `PCM_CRC_RESET;
      held_ok <= 1'b0;
      primed <= 1'b0;
    end else if (clear) begin
      crc <= `PCM_CRC_RESET;
      held_ok <= 1'b0;
      primed <= 1'b0;
    end else if (bit_en) begin
      crc <= next_crc;
      if (smf_start) begin
        held <= crc;
        held_ok <= primed;
        primed <= 1'b1;
      end
    end
  end

  // first block after lock has no predecessor, so no verdict
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mismatch <= 1'b0;
    end else begin
      mismatch <= check && held_ok && !clear && (held != rx_crc);
    end
  end

  property p_mismatch;
    @(posedge clock) disable iff (!rst_b) mismatch |-> $past(check) && $past(held_ok);
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("crc mismatch without check");
endmodule : pcm_crc4

// ### hdl/pcm_persist.sv
module pcm_persist import pcm_pkg::*; #(
  parameter int W = 8
) (
  input wire logic clock, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic clear, // hold state cleared
  input wire logic eval, // one observation
  input wire logic set_cond, // observation toward set
  input wire logic clr_cond, // observation toward clear
  input wire logic [W-1:0] consec, // observations needed, 0 acts as 1
  output logic state // filtered state
);
  if (W < 1 || W > 16) begin : g_bad_w
    $error("pcm_persist width out of range");
  end

  logic [W-1:0] run;
  wire toward = state ? clr_cond : set_cond;
  wire [W-1:0] next_run = toward ? W'(run + 1'b1) : '0;
  wire flip = toward && (next_run >= consec);

  // consecutive observations only; one contrary sample restarts the run
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run <= '0;
      state <= 1'b0;
    end else if (clear) begin
      run <= '0;
      state <= 1'b0;
    end else if (eval) begin
      run <= flip ? '0 : next_run;
      state <= flip ? !state : state;
    end
  end

  property p_rise;
    @(posedge clock) disable iff (!rst_b)
      $rose(state) |-> $past(eval) && $past(set_cond) && !$past(clear);
  endproperty
  a_rise: assert property (p_rise) else $error("state set without cause");

  property p_fall;
    @(posedge clock) disable iff (!rst_b)
      $fell(state) |-> $past(clear) || ($past(eval) && $past(clr_cond));
  endproperty
  a_fall: assert property (p_fall) else $error("state cleared without cause");
endmodule : pcm_persist

// ### dv/pcm_line_src.sv
`include "pcm_defines.svh"
// upstream framer model: e1 frames with crc-4 multiframe and error injection
module pcm_line_src (
  output logic line_clk, // 160 ns bit clock, runs free like a real line
  output logic line_data, // line data, changes after the falling edge
  output logic line_frame_start, // high with the first bit of a frame
  input wire logic fas_en, // corrupt the align word of even frames
  input wire logic crc_en, // flip one payload bit in the last frame of a submultiframe
  input wire logic e_en, // send both E bits as errors
  input wire logic a_val, // A bit value
  output int frame_cnt, // frames finished
  output int fas_cnt, // align words corrupted
  output int crc_cnt, // submultiframes corrupted
  output int e_cnt // E bits sent as errors
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] fas_word = `PCM_FAS_WORD;
  localparam logic [5:0] mfas_word = `PCM_MFAS_WORD;
  logic [3:0] crc;
  logic [3:0] sent_crc;
  logic [7:0] pat;
  logic fas_f;
  logic crc_f;
  logic e_f;
  logic b;
  logic cb;
  int fr;
  // bit serial source; crc is taken before the flip so the far end sees a mismatch
  initial begin
    {line_clk, line_data, line_frame_start, crc, sent_crc} = '0;
    {frame_cnt, fas_cnt, crc_cnt, e_cnt} = '0;
    pat = 8'h5a;
    forever begin
      fr = frame_cnt % 16;
      fas_f = fas_en && fr % 2 == 0;
      crc_f = crc_en && fr % 8 == 7;
      e_f = e_en && (fr == 13 || fr == 15);
      fas_cnt += int'(fas_f);
      crc_cnt += int'(crc_f);
      e_cnt += int'(e_f);
      for (int pos = 0; pos < 256; pos++) begin
        pat = {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]}; // payload never sits still
        b = pat[0];
        if (pos == 0 && fr % 2 == 0) b = sent_crc[3 - (fr % 8) / 2];
        if (pos == 0 && fr % 2 == 1) b = (fr < 12) ? mfas_word[5 - fr / 2] : !e_f;
        if (pos > 0 && pos < 8 && fr % 2 == 0) b = fas_word[7 - pos];
        if (pos == 1 && fr % 2 == 1) b = 1'b1;
        if (pos == 2 && fr % 2 == 1) b = a_val;
        // align errors go out with a matching crc, so crc mode must not count them
        if (fas_f && pos == 5) b = !b;
        cb = (pos == 0 && fr % 2 == 0) ? 1'b0 : b;
        crc = {crc[2:0], 1'b0} ^ ((crc[3] ^ cb) ? `PCM_CRC_POLY : 4'h0);
        if (fr % 8 == 7 && pos == 255) begin
          sent_crc = crc;
          crc = 4'h0;
        end
        line_data = b ^ (crc_f && pos == 100);
        line_frame_start = (pos == 0);
        #80 line_clk = 1'b1;
        #80 line_clk = 1'b0;
      end
      frame_cnt++;
    end
  end
endmodule : pcm_line_src

// ### dv/test_pcm_path_monitor.sv
`include "pcm_defines.svh"
module test_pcm_path_monitor import pcm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b, line_clk, line_data, line_frame_start;
  logic server_fail_in, multiframe_loss_in, equipment_defect, one_second_tick;
  logic monitoring_active, remote_defect_report_en, server_fail_report_en;
  logic crc_count_select, auto_interwork_mode;
  logic [3:0] deg_seconds;
  logic [`PCM_CNT_W-1:0] deg_threshold;
  logic trail_fail_out, trail_degrade_out, degrade_fault_cause, remote_defect_fault_cause;
  logic server_fail_fault_cause, remote_defect, degraded_defect, crc_interwork_status;
  logic near_block_error, far_block_error, align_word_error, perf_valid;
  pcm_second_s perf_second;
  logic fas_en, crc_en, e_en, a_val;
  int frame_cnt, fas_cnt, crc_cnt, e_cnt, f0, c0, e0;
  int num_errors = 0;
  int check_count = 0;
  int awe_cnt = 0;

  // align error pulses, sampled mid-cycle where they are settled
  always @(negedge clock) awe_cnt += int'(align_word_error === 1'b1);

  pcm_path_monitor pcm_path_monitor_inst (.clock, .rst_b, .line_clk, .line_data,
    .line_frame_start, .server_fail_in, .multiframe_loss_in, .equipment_defect,
    .one_second_tick, .monitoring_active, .remote_defect_report_en, .server_fail_report_en,
    .crc_count_select, .auto_interwork_mode, .deg_seconds, .deg_threshold, .trail_fail_out,
    .trail_degrade_out, .degrade_fault_cause, .remote_defect_fault_cause,
    .server_fail_fault_cause, .remote_defect, .degraded_defect, .crc_interwork_status,
    .near_block_error, .far_block_error, .align_word_error, .perf_valid, .perf_second);

  pcm_line_src pcm_line_src_inst (.line_clk, .line_data, .line_frame_start, .fas_en,
    .crc_en, .e_en, .a_val, .frame_cnt, .fas_cnt, .crc_cnt, .e_cnt);

  // 125 mhz system clock
  initial forever #4 clock = ~clock;

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask : cycles

  // bounded in clock cycles as well as on the model's frame counter; a stuck line ends the run
  task automatic wait_frames(input int n);
    int target;
    target = frame_cnt + n;
    for (int k = 0; k < n * 5200 + 200 && frame_cnt < target; k++) @(posedge clock);
    if (frame_cnt < target) begin
      num_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, frame_cnt, target);
      print_verdict();
    end
  endtask : wait_frames

  // tick only while the line is quiet, so no event straddles the boundary
  task automatic second(input int nc, input logic nds, input int fc, input logic fds);
    @(posedge clock);
    one_second_tick <= 1'b1;
    @(posedge clock);
    one_second_tick <= 1'b0;
    @(negedge clock);
    chk(16'(perf_valid), 16'h0001);
    chk(16'(perf_second.near_count), 16'(nc));
    chk(16'(perf_second.near_ds), 16'(nds));
    chk(16'(perf_second.far_count), 16'(fc));
    chk(16'(perf_second.far_ds), 16'(fds));
  endtask : second

  // main sequence: align word second, crc second, equipment defect second
  initial begin
    {rst_b, server_fail_in, multiframe_loss_in, equipment_defect, one_second_tick} = '0;
    {remote_defect_report_en, monitoring_active, a_val, e_en} = '1;
    {server_fail_report_en, crc_count_select, auto_interwork_mode, fas_en, crc_en} = '0;
    deg_seconds = 4'h1;
    deg_threshold = 13'h0001; // one errored block makes a bad second
    repeat (9) @(posedge clock);
    @(negedge clock);
    chk(16'({perf_valid, remote_defect, trail_fail_out, crc_interwork_status}), 16'h0000);
    @(posedge clock);
    rst_b <= 1'b1;
    wait_frames(1);
    fas_en <= 1'b1;
    f0 = fas_cnt;
    wait_frames(11);
    fas_en <= 1'b0;
    wait_frames(1);
    @(negedge clock);
    chk(16'(remote_defect), 16'h0001);
    chk(16'(remote_defect_fault_cause), 16'h0001);
    cycles(1);
    remote_defect_report_en <= 1'b0;
    cycles(4);
    chk(16'(remote_defect_fault_cause), 16'h0000);
    server_fail_in <= 1'b1;
    cycles(8);
    chk(16'({trail_fail_out, server_fail_fault_cause, remote_defect}), 16'h0004);
    server_fail_report_en <= 1'b1;
    a_val <= 1'b0;
    cycles(4);
    chk(16'(server_fail_fault_cause), 16'h0001);
    server_fail_in <= 1'b0;
    cycles(8);
    chk(16'(trail_fail_out), 16'h0000);
    chk(16'(awe_cnt), 16'(fas_cnt - f0));
    second(fas_cnt - f0, 1'b1, 0, 1'b1);
    cycles(4);
    @(negedge clock);
    chk(16'({degraded_defect, trail_degrade_out, degrade_fault_cause}), 16'h0007);
    chk(16'(crc_interwork_status), 16'h0000);
    cycles(1);
    monitoring_active <= 1'b0;
    cycles(4);
    chk(16'(degrade_fault_cause), 16'h0000);
    {monitoring_active, crc_count_select, auto_interwork_mode, fas_en} <= '1;
    e0 = e_cnt;
    // the block cut by the lock is never judged, so corrupt the first whole one
    wait_frames(4);
    crc_en <= 1'b1;
    c0 = crc_cnt;
    wait_frames(7);
    {crc_en, fas_en, e_en} <= '0;
    wait_frames(7);
    multiframe_loss_in <= 1'b1;
    cycles(10);
    multiframe_loss_in <= 1'b0;
    cycles(8);
    second(crc_cnt - c0, 1'b1, e_cnt - e0, 1'b0);
    cycles(4);
    @(negedge clock);
    chk(16'(crc_interwork_status), 16'h0000);
    cycles(1);
    equipment_defect <= 1'b1;
    cycles(5);
    equipment_defect <= 1'b0;
    cycles(2);
    second(0, 1'b1, 0, 1'b0);
    cycles(4);
    @(negedge clock);
    chk(16'(degraded_defect), 16'h0000);
    print_verdict();
  end
endmodule : test_pcm_path_monitor
